// ===== core/crc_defs.vh
// constants for the completion request counter block
//
// Notes on behaviour
// RULE1 - count up on reporting request submission
// RULE2 - count down per valid returned completion code
// RULE3 - simultaneous codes drop count by full number
// RULE4 - count saturates at 0x3F on increment
// RULE5 - no request issue while count saturated
// RULE6 - saturation sets error bit, raises interrupt
// RULE7 - count readable in controller status register
// RULE8 - direct requests decrement but never increment
// RULE9 - software polls count, keeps below 0x30
// RULE10 - software reserves one controller and code
// RULE11 - six-bit count wraps zero to maximum
// RULE12 - direct transfer starts on index register write
// RULE13 - completion sets pending bit by code
// RULE14 - simultaneous up and down apply net sum
`ifndef CRC_DEFS_VH
`define CRC_DEFS_VH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define CRC_ADDR_W          8
`define CRC_OFS_STATUS      8'h00
`define CRC_OFS_ERROR       8'h04
`define CRC_OFS_ERRCLR      8'h08
`define CRC_OFS_ERREN       8'h0C
`define CRC_OFS_PENDING     8'h10
`define CRC_OFS_PENDCLR     8'h14
`define CRC_OFS_PENDEN      8'h18
`define CRC_OFS_INTSTAT     8'h1C
`define CRC_OFS_INTCLR      8'h20
`define CRC_OFS_INTEN       8'h24
`define CRC_OFS_DOPT        8'h28
`define CRC_OFS_DSRC        8'h2C
`define CRC_OFS_DCNT        8'h30
`define CRC_OFS_DDST        8'h34
`define CRC_OFS_DBIDX       8'h38

// ----------------------------------------
// counter and fields
// ----------------------------------------
`define CRC_CNT_W           6
`define CRC_CNT_MAX         6'h3F
`define CRC_NUM_TC          6
`define CRC_CODE_W          6
`define CRC_NUM_CODES       64
`define CRC_STAT_CNT_LSB    8
`define CRC_ERR_CNT_BIT     16
// options word fields
`define CRC_OPT_INTERMEDIATE_COMPLETION_CHAIN_ENABLE     23
`define CRC_OPT_FINAL_COMPLETION_CHAIN_ENABLE      22
`define CRC_OPT_INTERMEDIATE_COMPLETION_INTERRUPT_ENABLE    21
`define CRC_OPT_FINAL_COMPLETION_INTERRUPT_ENABLE     20
`define CRC_OPT_CODE_LSB    12
// interrupt status bits
`define CRC_INT_ERR         0
`define CRC_INT_DONE        1
`define CRC_INT_DIRECT      2
`define CRC_INT_W           3

`endif

// ===== core/crc_count_unit.v
// outstanding completion counter with saturation and wrap
`include "crc_defs.vh"

module crc_count_unit
(
	input  wire                    clk,       // system clock
	input  wire                    srst,      // sync reset
	input  wire                    incReq,    // counted submission
	input  wire [`CRC_NUM_TC-1:0]  codeValid, // per controller code returns
	output reg  [`CRC_CNT_W-1:0]   count_q,   // outstanding count
	output wire                    saturated  // count at maximum
);

	// ----------------------------------------
	// population count of returned codes
	// ----------------------------------------
	function [3:0] crcPopCount;
		input [`CRC_NUM_TC-1:0] v;
		integer i;
		begin
			crcPopCount = 4'h0;
			for (i = 0; i < `CRC_NUM_TC; i = i + 1)
				crcPopCount = crcPopCount + {3'h0, v[i]};
		end
	endfunction

	wire [3:0]           decCount;
	reg  [`CRC_CNT_W-1:0] count_d;

	assign decCount  = crcPopCount(codeValid);             // RULE3
	assign saturated = (count_q == `CRC_CNT_MAX);

	// net change; increment blocked at max, decrement wraps (modulo)
	always @*
	begin
		count_d = count_q - {2'h0, decCount};               // RULE2 RULE11
		if (incReq && !saturated)
			count_d = count_d + 6'h01;                      // RULE1 RULE4 RULE14
	end

	always @(posedge clk)
	begin
		if (srst)
			count_q <= 6'h00;
		else
			count_q <= count_d;
	end

endmodule // crc_count_unit

// ===== core/crc_direct_prog.v
// direct programming set of one transfer controller
`include "crc_defs.vh"

module crc_direct_prog
(
	input  wire                    clk,        // system clock
	input  wire                    srst,       // sync reset
	input  wire                    wrOpt,      // options word write
	input  wire                    wrTrig,     // index register write
	input  wire [31:0]             wrData,     // write data
	output reg  [31:0]             opt_q,      // held options word
	output reg                     start_q,    // start pulse
	output wire [`CRC_CODE_W-1:0]  code,       // completion code
	output wire                    reportReq   // completion reporting wanted
);

	assign code      = opt_q[`CRC_OPT_CODE_LSB +: `CRC_CODE_W];
	assign reportReq = opt_q[`CRC_OPT_FINAL_COMPLETION_INTERRUPT_ENABLE] | opt_q[`CRC_OPT_INTERMEDIATE_COMPLETION_INTERRUPT_ENABLE]
		| opt_q[`CRC_OPT_FINAL_COMPLETION_CHAIN_ENABLE] | opt_q[`CRC_OPT_INTERMEDIATE_COMPLETION_CHAIN_ENABLE];

	// the index write is the last of the set and fires the transfer
	always @(posedge clk)
	begin
		if (srst)
		begin
			opt_q   <= 32'h0000_0000;
			start_q <= 1'b0;
		end
		else
		begin
			if (wrOpt)
				opt_q <= wrData;
			start_q <= wrTrig;                                 // RULE12
		end
	end

endmodule // crc_direct_prog

// ===== core/crc_channel_ctrl.v
// channel controller completion accounting: counter, issue gate, regs
//
// The register offsets and the address-and-strobe port were decided locally.
`include "crc_defs.vh"

module crc_channel_ctrl
(
	input  wire                        clk,           // 40 MHz clock
	input  wire                        srst,          // sync reset, high
	input  wire [`CRC_ADDR_W-1:0]      regAddr,       // register address
	input  wire [31:0]                 regWrData,     // write data
	input  wire                        regWr,         // write strobe
	input  wire                        regRd,         // read strobe
	output reg  [31:0]                 regRdData_q,   // read data, next cycle
	input  wire                        trValid,       // request wants issue
	input  wire [31:0]                 trOpt,         // request options word
	output wire                        trReady,       // request taken
	input  wire [`CRC_NUM_TC-1:0]      tcDoneValid,   // completion returns
	input  wire [`CRC_NUM_TC*`CRC_CODE_W-1:0] tcDoneCode, // returned codes
	input  wire [`CRC_NUM_TC-1:0]      tcDoneIntEn,   // returned irq enables
	output reg                         directStart_q, // direct transfer start
	output wire [31:0]                 directOpt,     // direct options word
	output reg  [31:0]                 directSrc_q,   // direct source
	output reg  [31:0]                 directCnt_q,   // direct count
	output reg  [31:0]                 directDst_q,   // direct destination
	output reg  [31:0]                 directBidx_q,  // direct index
	output wire                        irq            // level interrupt
);

	// ----------------------------------------
	// address decode
	// ----------------------------------------
	wire wrErrClr  = regWr && (regAddr == `CRC_OFS_ERRCLR);
	wire wrErrEn   = regWr && (regAddr == `CRC_OFS_ERREN);
	wire wrPendClr = regWr && (regAddr == `CRC_OFS_PENDCLR);
	wire wrPendEn  = regWr && (regAddr == `CRC_OFS_PENDEN);
	wire wrIntClr  = regWr && (regAddr == `CRC_OFS_INTCLR);
	wire wrIntEn   = regWr && (regAddr == `CRC_OFS_INTEN);
	wire wrDOpt    = regWr && (regAddr == `CRC_OFS_DOPT);
	wire wrDSrc    = regWr && (regAddr == `CRC_OFS_DSRC);
	wire wrDCnt    = regWr && (regAddr == `CRC_OFS_DCNT);
	wire wrDDst    = regWr && (regAddr == `CRC_OFS_DDST);
	wire wrDBidx   = regWr && (regAddr == `CRC_OFS_DBIDX);

	// ----------------------------------------
	// request issue and counting
	// ----------------------------------------
	wire [`CRC_CNT_W-1:0] count;
	wire                  saturated;
	wire                  trFire;
	wire                  trReports;

	assign trReady   = !saturated;                              // RULE5
	assign trFire    = trValid && trReady;
	assign trReports = trOpt[`CRC_OPT_FINAL_COMPLETION_INTERRUPT_ENABLE] | trOpt[`CRC_OPT_INTERMEDIATE_COMPLETION_INTERRUPT_ENABLE]
		| trOpt[`CRC_OPT_FINAL_COMPLETION_CHAIN_ENABLE] | trOpt[`CRC_OPT_INTERMEDIATE_COMPLETION_CHAIN_ENABLE];   // RULE1

	// direct-programmed starts never reach incReq
	crc_count_unit uCount
	(
		.clk       (clk),
		.srst      (srst),
		.incReq    (trFire && trReports),                       // RULE1 RULE8
		.codeValid (tcDoneValid),                               // RULE2 RULE8
		.count_q   (count),
		.saturated (saturated)
	);

	wire                   directStart;
	wire [`CRC_CODE_W-1:0] directCode;
	wire                   directReport;

	crc_direct_prog uDirect
	(
		.clk       (clk),
		.srst      (srst),
		.wrOpt     (wrDOpt),
		.wrTrig    (wrDBidx),
		.wrData    (regWrData),
		.opt_q     (directOpt),
		.start_q   (directStart),
		.code      (directCode),
		.reportReq (directReport)
	);

	// other direct registers, held for the transfer controller
	always @(posedge clk)
	begin
		if (srst)
		begin
			directSrc_q   <= 32'h0000_0000;
			directCnt_q   <= 32'h0000_0000;
			directDst_q   <= 32'h0000_0000;
			directBidx_q  <= 32'h0000_0000;
			directStart_q <= 1'b0;
		end
		else
		begin
			if (wrDSrc)
				directSrc_q <= regWrData;
			if (wrDCnt)
				directCnt_q <= regWrData;
			if (wrDDst)
				directDst_q <= regWrData;
			if (wrDBidx)
				directBidx_q <= regWrData;
			directStart_q <= directStart;                        // RULE12
		end
	end

	// ----------------------------------------
	// saturation error and pending bits
	// ----------------------------------------
	reg                      sat_q;
	reg                      cntErr_q;
	reg                      errEn_q;
	reg  [`CRC_NUM_CODES-1:0] pend_q;
	reg  [`CRC_NUM_CODES-1:0] pendSet;
	reg  [`CRC_CODE_W-1:0]   pendEnCode_q;
	reg                      pendEnValid_q;
	integer                  k;

	// entry into saturation, seen once per arrival
	wire satRise = saturated && !sat_q;

	// set wins over clear on the error bit
	always @(posedge clk)
	begin
		if (srst)
		begin
			sat_q    <= 1'b0;
			cntErr_q <= 1'b0;
			errEn_q  <= 1'b0;
		end
		else
		begin
			sat_q <= saturated;
			if (satRise)
				cntErr_q <= 1'b1;                                // RULE6
			else if (wrErrClr && regWrData[`CRC_ERR_CNT_BIT])
				cntErr_q <= 1'b0;
			if (wrErrEn)
				errEn_q <= regWrData[`CRC_ERR_CNT_BIT];
		end
	end

	// pending bits by completion code, any controller, same cycle
	always @*
	begin
		pendSet = {`CRC_NUM_CODES{1'b0}};
		for (k = 0; k < `CRC_NUM_TC; k = k + 1)
			if (tcDoneValid[k] && tcDoneIntEn[k])
				pendSet[tcDoneCode[k*`CRC_CODE_W +: `CRC_CODE_W]] = 1'b1; // RULE13
	end

	always @(posedge clk)
	begin
		if (srst)
		begin
			pend_q        <= {`CRC_NUM_CODES{1'b0}};
			pendEnCode_q  <= 6'h00;
			pendEnValid_q <= 1'b0;
		end
		else
		begin
			if (wrPendClr)
				pend_q <= (pend_q & ~{32'h0000_0000, regWrData}) | pendSet;
			else
				pend_q <= pend_q | pendSet;                      // RULE13
			// one code may be watched for a completion interrupt
			if (wrPendEn)
			begin
				pendEnCode_q  <= regWrData[`CRC_CODE_W-1:0];
				pendEnValid_q <= regWrData[31];
			end
		end
	end

	// ----------------------------------------
	// interrupt status, clear and enable
	// ----------------------------------------
	reg  [`CRC_INT_W-1:0] intStat_q;
	reg  [`CRC_INT_W-1:0] intEn_q;
	wire [`CRC_INT_W-1:0] intEvt;

	assign intEvt = {directStart,
		pendEnValid_q && pendSet[pendEnCode_q],
		satRise && errEn_q};                                    // RULE6

	always @(posedge clk)
	begin
		if (srst)
		begin
			intStat_q <= 3'h0;
			intEn_q   <= 3'h0;
		end
		else
		begin
			if (wrIntClr)
				intStat_q <= (intStat_q & ~regWrData[`CRC_INT_W-1:0]) | intEvt;
			else
				intStat_q <= intStat_q | intEvt;
			if (wrIntEn)
				intEn_q <= regWrData[`CRC_INT_W-1:0];
		end
	end

	assign irq = |(intStat_q & intEn_q);                        // RULE6

	// ----------------------------------------
	// read mux, unmapped reads as zero
	// ----------------------------------------
	always @(posedge clk)
	begin
		if (srst)
			regRdData_q <= 32'h0000_0000;
		else if (regRd)
		begin
			if (regAddr == `CRC_OFS_STATUS)
				regRdData_q <= {18'h0_0000, count, 7'h00, saturated}; // RULE7
			else if (regAddr == `CRC_OFS_ERROR)
				regRdData_q <= {15'h0000, cntErr_q, 16'h0000};
			else if (regAddr == `CRC_OFS_ERREN)
				regRdData_q <= {15'h0000, errEn_q, 16'h0000};
			else if (regAddr == `CRC_OFS_PENDING)
				regRdData_q <= pend_q[31:0];
			else if (regAddr == `CRC_OFS_PENDEN)
				regRdData_q <= {pendEnValid_q, 25'h000_0000, pendEnCode_q};
			else if (regAddr == `CRC_OFS_INTSTAT)
				regRdData_q <= {29'h0000_0000, intStat_q};
			else if (regAddr == `CRC_OFS_INTEN)
				regRdData_q <= {29'h0000_0000, intEn_q};
			else if (regAddr == `CRC_OFS_DOPT)
				regRdData_q <= directOpt;
			else
				regRdData_q <= 32'h0000_0000;
		end
		else
			regRdData_q <= 32'h0000_0000;
	end

	// directCode/directReport are informational for the controller
	wire unusedDirect = directReport ^ (|directCode);

endmodule // crc_channel_ctrl

// ===== verif/crc_tc_model.sv
// model of six transfer controllers returning completion codes
module crc_tc_model
(
	input  logic        clk,                  // clock
	input  logic        srst,                 // sync reset
	input  logic [5:0]  retMask,              // controllers told to finish
	input  logic        directStart_q,        // software started controller 5
	input  logic [31:0] directOpt,            // its options word
	output logic [5:0]  tcDoneValid = 6'h00,  // one pulse per completion
	output logic [35:0] tcDoneCode  = 36'h0,  // code of each controller
	output logic [5:0]  tcDoneIntEn = 6'h00   // completion interrupt wanted
);
	timeunit 1ns;
	timeprecision 1ps;
	// idle code lines flip each cycle so a stale code never looks valid
	always @(posedge clk)
	begin
		tcDoneValid <= srst ? 6'h00 : retMask | {directStart_q, 5'h00};
		tcDoneIntEn <= retMask | {directStart_q & directOpt[20], 5'h00};
		for (int k = 0; k < 6; k++)
			tcDoneCode[6*k +: 6] <= (k == 5 && directStart_q) ? directOpt[17:12] :
				retMask[k] ? 6'(k) : ~tcDoneCode[6*k +: 6];
	end
endmodule // crc_tc_model

// ===== verif/crc_channel_ctrl_properties.sv
// assertions on the channel controller completion accounting
module crc_channel_ctrl_properties
(
	input wire logic        clk,           // clock
	input wire logic        srst,          // sync reset
	input wire logic [7:0]  regAddr,       // address
	input wire logic        regWr,         // write strobe
	input wire logic        regRd,         // read strobe
	input wire logic [31:0] regRdData_q,   // read data
	input wire logic        trValid,       // request offered
	input wire logic [31:0] trOpt,         // options word
	input wire logic        trReady,       // request taken
	input wire logic [5:0]  tcDoneValid,   // completions
	input wire logic        directStart_q  // direct start
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [5:0] cntM;
	wire  [5:0] nDone = {5'h00, tcDoneValid[0]} + tcDoneValid[1] + tcDoneValid[2]
		+ tcDoneValid[3] + tcDoneValid[4] + tcDoneValid[5];
	wire        take = trValid && trReady && |trOpt[23:20];
	// shadow count, wraps like the real one so the flag can be judged each cycle
	always @(posedge clk)
		cntM <= srst ? 6'h00 : cntM - nDone + {5'h00, take};
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	a_ready_vs_count: assert property (trReady == (cntM != 6'h3F))
		else $error("ready flag and count disagree");
	a_status_count: assert property (regRd && regAddr == 8'h00 |=>
		regRdData_q[13:0] == {$past(cntM), 7'h00, $past(cntM) == 6'h3F}) else $error("status");
	a_max_stops: assert property (!trReady && nDone == 6'h00 |=> !trReady)
		else $error("count left the top without a code");
	a_code_resumes: assert property (!trReady && nDone != 6'h00 |=> trReady)
		else $error("issue did not resume");
	a_fill_to_max: assert property (cntM == 6'h3E && take && nDone == 6'h00 |=> !trReady)
		else $error("count did not reach the top");
	a_wrap_under: assert property (cntM + 6'h01 == nDone && !take |=> !trReady)
		else $error("underflow did not wrap");
	a_start_delay: assert property (regWr && regAddr == 8'h38 |-> ##2 directStart_q)
		else $error("direct start missing");
	a_start_cause: assert property (directStart_q |-> $past(regWr && regAddr == 8'h38, 2))
		else $error("direct start without trigger");
	c_full: cover property ($fell(trReady));
	c_multi: cover property (nDone > 6'h01);
	c_direct: cover property (directStart_q);
endmodule // crc_channel_ctrl_properties
bind crc_channel_ctrl crc_channel_ctrl_properties i_crc_channel_ctrl_properties (.clk, .srst,
	.regAddr, .regWr, .regRd, .regRdData_q, .trValid, .trOpt, .trReady, .tcDoneValid,
	.directStart_q);

// ===== verif/tb_crc_channel_ctrl.sv
// testbench of the channel controller completion accounting
module tb_crc_channel_ctrl;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 0, srst = 1, regWr = 0, regRd = 0, trValid = 0;
	logic [7:0]  regAddr = 8'h00;
	logic [31:0] regWrData = 0, trOpt = 0, rdq, directOpt;
	logic [5:0]  retMask = 6'h00, tcDoneValid, tcDoneIntEn;
	logic [35:0] tcDoneCode;
	logic        trReady, irq, directStart_q;
	int          mismatches = 0, comparisons = 0, i;
	crc_channel_ctrl i_crc_channel_ctrl (.clk, .srst, .regAddr, .regWrData, .regWr, .regRd,
		.regRdData_q(rdq), .trValid, .trOpt, .trReady, .tcDoneValid, .tcDoneCode, .tcDoneIntEn,
		.directStart_q, .directOpt, .directSrc_q(), .directCnt_q(), .directDst_q(),
		.directBidx_q(), .irq);
	crc_tc_model i_crc_tc_model (.clk, .srst, .retMask, .directStart_q, .directOpt,
		.tcDoneValid, .tcDoneCode, .tcDoneIntEn);
	always #12.5 clk = ~clk;
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e)
		begin
			mismatches++;
			$display("Error %0t seen %h exp %h", $time, s, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1;
		@(posedge clk);
		regWr <= 0;
		#1;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e); // read and compare
		@(posedge clk);
		regAddr <= a;
		regRd <= 1;
		@(posedge clk);
		regRd <= 0;
		#1 chk(rdq, e);
	endtask
	task automatic sub(input logic [31:0] o); // offer until taken
		@(posedge clk);
		trValid <= 1;
		trOpt <= o;
		i = 0;
		do
			@(negedge clk);
		while (trReady !== 1'b1 && ++i < 300);
		if (i == 300)
		begin
			mismatches++;
			results();
		end
		@(posedge clk);
		trValid <= 0;
	endtask
	task automatic ret(input logic [5:0] m); // completions from the model
		@(posedge clk);
		retMask <= m;
		@(posedge clk);
		retMask <= 6'h00;
	endtask
	task automatic t_reset;
		rd(8'h00, 32'h0000_0000);
		chk(trReady, 1);
		rd(8'hFC, 32'h0000_0000);
	endtask
	task automatic t_count; // every report bit counts, a silent request does not
		for (int k = 20; k < 24; k++)
			sub(32'h0000_0001 << k);
		sub(32'h0003_F000);
		rd(8'h00, 32'h0000_0400);
		ret(6'h07);
		rd(8'h00, 32'h0000_0100);
		rd(8'h10, 32'h0000_0007);
	endtask
	task automatic t_net; // up and down in one cycle, then underflow
		@(posedge clk);
		retMask <= 6'h03;
		@(posedge clk);
		retMask <= 6'h00;
		trValid <= 1;
		trOpt <= 32'h0010_0000;
		@(posedge clk);
		trValid <= 0;
		rd(8'h00, 32'h0000_0000);
		ret(6'h01);
		rd(8'h00, 32'h0000_3F01);
		rd(8'h04, 32'h0001_0000);
		wr(8'h08, 32'h0001_0000);
		ret(6'h30);
		rd(8'h00, 32'h0000_3D00);
		rd(8'h04, 32'h0000_0000);
	endtask
	task automatic t_sat; // fill, refuse while full, signal, resume
		for (int k = 0; k < 11; k++)
			ret(k < 10 ? 6'h3F : 6'h01);
		wr(8'h0C, 32'h0001_0000);
		wr(8'h24, 32'h0000_0001);
		for (int k = 0; k < 63; k++)
			sub(32'h0080_0000);
		trValid <= 1;
		repeat (3) @(posedge clk);
		rd(8'h00, 32'h0000_3F01);
		chk(trReady, 0);
		chk(irq, 1);
		wr(8'h24, 32'h0000_0000);
		chk(irq, 0);
		ret(6'h01);
		rd(8'h00, 32'h0000_3E00);
		rd(8'h00, 32'h0000_3F01);
		trValid <= 0;
		for (int k = 0; k < 10; k++)
			ret(6'h3F);
	endtask
	task automatic t_direct; // software transfer on the reserved controller
		wr(8'h20, 32'h0000_0007);
		wr(8'h18, 32'h8000_003F);
		for (int k = 8'h28; k < 8'h38; k += 4)
			wr(8'(k), k == 8'h28 ? 32'h0013_F000 : 32'h0000_0000);
		wr(8'h38, 32'h0000_0000);
		@(posedge clk);
		#1 chk(directStart_q, 1);
		repeat (2) @(posedge clk);
		rd(8'h00, 32'h0000_0200);
		rd(8'h1C, 32'h0000_0006);
		rd(8'h28, 32'h0013_F000);
		chk(directOpt, 32'h0013_F000);
	endtask
	task automatic results;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// main sequence
	initial
	begin
		repeat (10) @(posedge clk);
		srst <= 0;
		t_reset;
		t_count;
		t_net;
		t_sat;
		t_direct;
		results;
	end
endmodule // tb_crc_channel_ctrl
